// ---- hdl/nic_pkg.sv ----
// nic_pkg: constants and carrier types for the name identifier codec
// assumes: 128-bit name held as word0 in bits 127:96 down to word3 in bits 31:0
package nic_pkg;

  localparam int NIC_NAME_W   = 128;
  localparam int NIC_CODE_MSB = 127;
  localparam int NIC_CODE_W   = 4;

  // format codes
  localparam logic [3:0] NIC_FMT_ABSENT  = 4'h0;
  localparam logic [3:0] NIC_FMT_LAN48   = 4'h1;
  localparam logic [3:0] NIC_FMT_LANEXT  = 4'h2;
  localparam logic [3:0] NIC_FMT_LOCAL   = 4'h3;
  localparam logic [3:0] NIC_FMT_REG     = 4'h5;
  localparam logic [3:0] NIC_FMT_REGEXT  = 4'h6;
  localparam logic [3:0] NIC_FMT_EUI_LO  = 4'hC;

  // field positions within the 128-bit name
  localparam int NIC_EXT12_MSB = 123;
  localparam int NIC_PAD12_MSB = 123;
  localparam int NIC_ULA_MSB   = 111;
  localparam int NIC_ULA_LAN0  = 104;
  localparam int NIC_LOCAL_MSB = 123;
  localparam int NIC_ORG_MSB   = 123;
  localparam int NIC_VENDOR_SPECIFIC_ID_MSB  = 99;
  localparam int NIC_VEXT_MSB  = 63;
  localparam int NIC_EUI_ONES  = 127;
  localparam int NIC_EUI_HI    = 125;
  localparam int NIC_EUI_LO    = 119;
  localparam int NIC_EUI_VENDOR_SPECIFIC_ID  = 103;

  // field widths
  localparam int NIC_EXT12_W = 12;
  localparam int NIC_ULA_W   = 48;
  localparam int NIC_LOCAL_W = 60;
  localparam int NIC_ORG_W   = 24;
  localparam int NIC_VENDOR_SPECIFIC_ID_W  = 36;
  localparam int NIC_VEXT_W  = 64;
  localparam int NIC_EUIV_W  = 40;
  localparam int NIC_EUIH_W  = 6;
  localparam int NIC_EUIL_W  = 16;
  localparam int NIC_LANB_W  = 2;

  // lan bit position inside the address, eui marker width
  localparam int NIC_ULA_LANB   = 40;
  localparam int NIC_EUI_ONES_W = 2;

  typedef struct packed {
    logic [3:0]   name_format_code;
    logic [11:0]  vendor_ext12;
    logic [47:0]  universal_lan_address;
    logic [59:0]  local_value;
    logic [23:0]  registered_org_id;
    logic [35:0]  vendor_specific_id;
    logic [63:0]  vendor_id_ext;
    logic [39:0]  eui_vendor_id;
  } nic_fields_type;

  typedef struct packed {
    logic long_name;
    logic absent;
    logic unsupported;
    logic world_wide;
    logic lan_bit_error;
  } nic_flags_type;

  typedef struct packed {
    nic_fields_type fields;
    nic_flags_type  flags;
  } nic_decoded_type;

  typedef struct packed {
    logic [127:0]  name;
    nic_flags_type flags;
  } nic_encoded_type;

endpackage

// ---- hdl/nic_codec.sv ----
// nic_codec: encodes and decodes 64/128-bit name identifiers, one cycle each way
// assumes: login/link service logic on clock_i drives strobes and fields
`timescale 1ns/1ps

module nic_codec
  import nic_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic            dec_valid_i,
  input  wire logic [127:0]    dec_name_i,
  input  wire logic            enc_valid_i,
  input  wire nic_fields_type  enc_fields_i,
  output logic                 dec_valid_o,
  output nic_decoded_type      dec_out_o,
  output logic                 enc_valid_o,
  output nic_encoded_type      enc_out_o
);

  typedef enum logic [2:0] {
    NIC_CLS_ABSENT = 3'h0,
    NIC_CLS_LAN48  = 3'h1,
    NIC_CLS_LANEXT = 3'h3,
    NIC_CLS_LOCAL  = 3'h2,
    NIC_CLS_REG    = 3'h6,
    NIC_CLS_REGEXT = 3'h7,
    NIC_CLS_EUI    = 3'h5,
    NIC_CLS_RSVD   = 3'h4
  } nic_class_type;

  // classify a format code
  function automatic nic_class_type classify(input logic [3:0] code);
    nic_class_type cls;
    cls = NIC_CLS_RSVD;
    if (code >= NIC_FMT_EUI_LO)
      cls = NIC_CLS_EUI;
    else
    begin
      case (code)
        NIC_FMT_ABSENT: cls = NIC_CLS_ABSENT;
        NIC_FMT_LAN48:  cls = NIC_CLS_LAN48;
        NIC_FMT_LANEXT: cls = NIC_CLS_LANEXT;
        NIC_FMT_LOCAL:  cls = NIC_CLS_LOCAL;
        NIC_FMT_REG:    cls = NIC_CLS_REG;
        NIC_FMT_REGEXT: cls = NIC_CLS_REGEXT;
        default:        cls = NIC_CLS_RSVD;
      endcase
    end
    return cls;
  endfunction

  // status flags shared by both directions
  function automatic nic_flags_type make_flags(input nic_class_type cls,
                                               input logic lan_bad);
    nic_flags_type f;
    f.long_name     = (cls == NIC_CLS_REGEXT);
    f.absent        = (cls == NIC_CLS_ABSENT);
    f.unsupported   = (cls == NIC_CLS_RSVD);
    f.world_wide    = (cls == NIC_CLS_LAN48) || (cls == NIC_CLS_LANEXT)
                      || (cls == NIC_CLS_REG);
    f.lan_bit_error = lan_bad;
    return f;
  endfunction

  // ---------------- decode path ----------------
  wire logic [3:0]    dec_code  = dec_name_i[NIC_CODE_MSB -: NIC_CODE_W];
  wire nic_class_type dec_cls   = classify(dec_code);
  wire logic [11:0]   dec_ext12 = dec_name_i[NIC_EXT12_MSB -: NIC_EXT12_W];
  wire logic [47:0]   dec_ula   = dec_name_i[NIC_ULA_MSB -: NIC_ULA_W];
  wire logic [1:0]    dec_lanb  = dec_name_i[NIC_ULA_LAN0 +: NIC_LANB_W];
  wire logic          dec_is_lan = (dec_cls == NIC_CLS_LAN48)
                                   || (dec_cls == NIC_CLS_LANEXT);
  wire logic          dec_pad_bad = (dec_cls == NIC_CLS_LAN48)
                                    && (dec_ext12 != '0);
  wire logic          dec_lan_bad = (dec_is_lan && (dec_lanb != '0))
                                    || dec_pad_bad;
  wire logic [23:0]   dec_eui_org = {dec_name_i[NIC_EUI_HI -: NIC_EUIH_W],
                                     {(NIC_ORG_W-NIC_EUIH_W-NIC_EUIL_W){1'h0}},
                                     dec_name_i[NIC_EUI_LO -: NIC_EUIL_W]};

  nic_decoded_type dec_nxt;
  always_comb
  begin
    dec_nxt       = '0;
    dec_nxt.flags = make_flags(dec_cls, dec_lan_bad);
    dec_nxt.fields.name_format_code = dec_code;
    case (dec_cls)
      NIC_CLS_LAN48:
      begin
        dec_nxt.fields.universal_lan_address = dec_ula;
      end
      NIC_CLS_LANEXT:
      begin
        dec_nxt.fields.vendor_ext12          = dec_ext12;
        dec_nxt.fields.universal_lan_address = dec_ula;
      end
      NIC_CLS_LOCAL:
      begin
        dec_nxt.fields.local_value =
          dec_name_i[NIC_LOCAL_MSB -: NIC_LOCAL_W];
      end
      NIC_CLS_REG, NIC_CLS_REGEXT:
      begin
        dec_nxt.fields.registered_org_id =
          dec_name_i[NIC_ORG_MSB -: NIC_ORG_W];
        dec_nxt.fields.vendor_specific_id =
          dec_name_i[NIC_VENDOR_SPECIFIC_ID_MSB -: NIC_VENDOR_SPECIFIC_ID_W];
        if (dec_cls == NIC_CLS_REGEXT)
          dec_nxt.fields.vendor_id_ext =
            dec_name_i[NIC_VEXT_MSB -: NIC_VEXT_W];
      end
      NIC_CLS_EUI:
      begin
        dec_nxt.fields.registered_org_id = dec_eui_org;
        dec_nxt.fields.eui_vendor_id =
          dec_name_i[NIC_EUI_VENDOR_SPECIFIC_ID -: NIC_EUIV_W];
      end
      default:
      begin
        // absent or reserved: fields other than the format code stay zero
        dec_nxt.fields.name_format_code = dec_code;
      end
    endcase
  end

  // ---------------- encode path ----------------
  wire logic [3:0]    enc_code = enc_fields_i.name_format_code;
  wire nic_class_type enc_cls  = classify(enc_code);
  wire logic [47:0]   enc_ula_raw = enc_fields_i.universal_lan_address;
  wire logic          enc_is_lan  = (enc_cls == NIC_CLS_LAN48)
                                    || (enc_cls == NIC_CLS_LANEXT);
  wire logic          enc_lan_bad = enc_is_lan
                        && (enc_ula_raw[NIC_ULA_LANB +: NIC_LANB_W] != '0);
  // group and local bits of byte 0 forced clear
  wire logic [47:0]   enc_ula  = {enc_ula_raw[NIC_ULA_W-1 : NIC_ULA_LANB+NIC_LANB_W],
                                  {NIC_LANB_W{1'h0}},
                                  enc_ula_raw[NIC_ULA_LANB-1:0]};
  wire logic [23:0]   enc_org  = enc_fields_i.registered_org_id;

  nic_encoded_type enc_nxt;
  always_comb
  begin
    enc_nxt       = '0;
    enc_nxt.flags = make_flags(enc_cls, enc_lan_bad);
    enc_nxt.name[NIC_CODE_MSB -: NIC_CODE_W] = enc_code;
    case (enc_cls)
      NIC_CLS_LAN48:
      begin
        enc_nxt.name[NIC_ULA_MSB -: NIC_ULA_W] = enc_ula;
      end
      NIC_CLS_LANEXT:
      begin
        enc_nxt.name[NIC_EXT12_MSB -: NIC_EXT12_W] =
          enc_fields_i.vendor_ext12;
        enc_nxt.name[NIC_ULA_MSB -: NIC_ULA_W] = enc_ula;
      end
      NIC_CLS_LOCAL:
      begin
        enc_nxt.name[NIC_LOCAL_MSB -: NIC_LOCAL_W] =
          enc_fields_i.local_value;
      end
      NIC_CLS_REG, NIC_CLS_REGEXT:
      begin
        enc_nxt.name[NIC_ORG_MSB -: NIC_ORG_W] = enc_org;
        enc_nxt.name[NIC_VENDOR_SPECIFIC_ID_MSB -: NIC_VENDOR_SPECIFIC_ID_W] =
          enc_fields_i.vendor_specific_id;
        if (enc_cls == NIC_CLS_REGEXT)
          enc_nxt.name[NIC_VEXT_MSB -: NIC_VEXT_W] =
            enc_fields_i.vendor_id_ext;
      end
      NIC_CLS_EUI:
      begin
        enc_nxt.name[NIC_EUI_ONES -: NIC_EUI_ONES_W] = {NIC_EUI_ONES_W{1'h1}};
        enc_nxt.name[NIC_EUI_HI -: NIC_EUIH_W] =
          enc_org[NIC_ORG_W-1 -: NIC_EUIH_W];
        enc_nxt.name[NIC_EUI_LO -: NIC_EUIL_W] = enc_org[NIC_EUIL_W-1:0];
        enc_nxt.name[NIC_EUI_VENDOR_SPECIFIC_ID -: NIC_EUIV_W] = enc_fields_i.eui_vendor_id;
      end
      default:
      begin
        // absent keeps a zero value, reserved emits the code only
        enc_nxt.name[NIC_CODE_MSB -: NIC_CODE_W] = enc_code;
      end
    endcase
  end

  // ---------------- output registers ----------------
  logic            dec_valid_r;
  logic            enc_valid_r;
  nic_decoded_type dec_out_r;
  nic_encoded_type enc_out_r;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dec_valid_r <= 1'b0;
      enc_valid_r <= 1'b0;
    end
    else if (ce_i)
    begin
      dec_valid_r <= dec_valid_i;
      enc_valid_r <= enc_valid_i;
    end
  end

  // results hold until the next accepted strobe
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dec_out_r <= '0;
      enc_out_r <= '0;
    end
    else if (ce_i)
    begin
      if (dec_valid_i)
        dec_out_r <= dec_nxt;
      if (enc_valid_i)
        enc_out_r <= enc_nxt;
    end
  end

  assign dec_valid_o = dec_valid_r;
  assign dec_out_o   = dec_out_r;
  assign enc_valid_o = enc_valid_r;
  assign enc_out_o   = enc_out_r;

endmodule

// ---- verification/nic_link_model.sv ----
// nic_link_model: link service side, issues decode and encode requests to the codec
// assumes: bench commands change at the rising edge; requests go out one edge later
`timescale 1ns/1ps
module nic_link_model
  import nic_pkg::*;
(
  input  wire logic           clock_i,
  input  wire logic           rst_n_i,
  input  wire logic           cmd_dec_i,
  input  wire logic [127:0]   cmd_name_i,
  input  wire logic           cmd_enc_i,
  input  wire nic_fields_type cmd_fields_i,
  output logic                dec_valid_o,
  output logic [127:0]        dec_name_o,
  output logic                enc_valid_o,
  output nic_fields_type      enc_fields_o
);
  // idle data lines show the inverse of their previous value, so every second idle cycle repeats a stale copy
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      dec_valid_o  <= 1'b0;
      enc_valid_o  <= 1'b0;
      dec_name_o   <= '0;
      enc_fields_o <= '0;
    end
    else
    begin
      dec_valid_o  <= cmd_dec_i;
      enc_valid_o  <= cmd_enc_i;
      dec_name_o   <= cmd_dec_i ? cmd_name_i : ~dec_name_o;
      enc_fields_o <= cmd_enc_i ? cmd_fields_i : ~enc_fields_o;
    end
endmodule

// ---- verification/nic_codec_asserts.sv ----
// nic_codec_asserts: port checks for the name identifier codec
// assumes: bound to nic_codec, one clock domain
`timescale 1ns/1ps
module nic_codec_asserts
  import nic_pkg::*;
(
  input wire logic            clock_i,
  input wire logic            rst_n_i,
  input wire logic            ce_i,
  input wire logic            dec_valid_i,
  input wire logic [127:0]    dec_name_i,
  input wire logic            enc_valid_i,
  input wire nic_fields_type  enc_fields_i,
  input wire logic            dec_valid_o,
  input wire nic_decoded_type dec_out_o,
  input wire logic            enc_valid_o,
  input wire nic_encoded_type enc_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [3:0] dcode  = dec_name_i[127:124];
  wire logic [3:0] ecode  = enc_fields_i.name_format_code;
  wire logic [5:0] org_hi = enc_fields_i.registered_org_id[23:18];
  wire logic       dtake  = ce_i && dec_valid_i;
  wire logic       etake  = ce_i && enc_valid_i;
  dec_pulse_a: assert property (
    dtake |=> dec_valid_o ##1 (!dec_valid_o || $past(dtake) || !$past(ce_i)))
    else $error("decode answer pulse wrong");
  dec_code_a: assert property (
    dtake |=> dec_out_o.fields.name_format_code == $past(dcode))
    else $error("decoded format code wrong");
  dec_absent_a: assert property (
    dtake |=> dec_out_o.flags.absent == ($past(dcode) == 4'h0))
    else $error("absent flag wrong");
  dec_wwn_a: assert property (
    dtake |=> dec_out_o.flags.world_wide == ($past(dcode) inside {4'h1, 4'h2, 4'h5}))
    else $error("world wide flag wrong");
  dec_unsup_a: assert property (
    dtake && dcode inside {4'h4, [4'h7:4'hB]}
    |=> dec_out_o.flags.unsupported && dec_out_o.fields.universal_lan_address == 48'h0)
    else $error("reserved code not flagged");
  dec_lanbit_a: assert property (
    dtake && dcode == 4'h1 && dec_name_i[105:104] != 2'h0
    |=> dec_out_o.flags.lan_bit_error)
    else $error("lan address bits not flagged");
  enc_lan_a: assert property (
    etake && ecode == 4'h1
    |=> enc_valid_o && enc_out_o.name[123:112] == 12'h0 && enc_out_o.name[105:104] == 2'h0)
    else $error("lan address layout wrong");
  enc_eui_a: assert property (
    etake && ecode >= 4'hC |=> enc_out_o.name[127:120] == {2'h3, $past(org_hi)})
    else $error("eui top byte wrong");
  ce_hold_a: assert property (
    !ce_i |=> $stable(dec_out_o) && $stable(enc_out_o))
    else $error("outputs moved while disabled");
endmodule

// ---- verification/test_nic_codec.sv ----
// test_nic_codec: directed decode and encode checks through the link model
// assumes: nic_pkg compiled first
`timescale 1ns/1ps
module test_nic_codec;
  import nic_pkg::*;
  logic clock_i = 0, rst_n_i = 0, ce_i = 0, cmd_dec = 0, cmd_enc = 0;
  logic [127:0] cmd_name = '0;
  nic_fields_type cmd_fields = '0;
  wire logic dv, ev, dec_valid_o, enc_valid_o;
  wire logic [127:0] dn;
  nic_fields_type ef;
  nic_decoded_type dec_out_o, d;
  nic_encoded_type enc_out_o, e;
  int num_errors = 0, compares = 0, cycles = 0;
  nic_link_model i_link (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_dec_i(cmd_dec),
    .cmd_name_i(cmd_name), .cmd_enc_i(cmd_enc), .cmd_fields_i(cmd_fields),
    .dec_valid_o(dv), .dec_name_o(dn), .enc_valid_o(ev), .enc_fields_o(ef));
  nic_codec i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .dec_valid_i(dv),
    .dec_name_i(dn), .enc_valid_i(ev), .enc_fields_i(ef), .dec_valid_o(dec_valid_o),
    .dec_out_o(dec_out_o), .enc_valid_o(enc_valid_o), .enc_out_o(enc_out_o));
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task automatic cmp_dec(input nic_decoded_type x, input logic vld);
    compares++;
    if (dec_out_o !== x || dec_valid_o !== vld)
    begin
      num_errors++;
      $display("MISMATCH %0t decode result", $time);
    end
  endtask
  task automatic cmp_enc(input nic_encoded_type x, input logic vld);
    compares++;
    if (enc_out_o !== x || enc_valid_o !== vld)
    begin
      num_errors++;
      $display("MISMATCH %0t encode result", $time);
    end
  endtask
  task automatic dec(input logic [127:0] n, input nic_decoded_type x);
    @(posedge clock_i) cmd_dec <= 1'b1;
    cmd_name <= n;
    @(posedge clock_i) cmd_dec <= 1'b0;
    @(posedge clock_i) #1 cmp_dec(x, ce_i);
  endtask
  task automatic enc(input nic_fields_type f, input nic_encoded_type x);
    @(posedge clock_i) cmd_enc <= 1'b1;
    cmd_fields <= f;
    @(posedge clock_i) cmd_enc <= 1'b0;
    @(posedge clock_i) #1 cmp_enc(x, 1'b1);
  endtask
  task automatic t_decode;
    d = '0;
    d.fields.name_format_code = 4'h1;
    d.flags.world_wide = 1'h1;
    d.fields.universal_lan_address = 48'h3C5A94000080;
    dec({64'h10003C5A94000080, 64'hFFFF}, d);
    d.fields.name_format_code = 4'h2;
    d.fields.vendor_ext12 = 12'hB17;
    dec({64'h2B173C5A94000080, 64'h0}, d);
    d = '0;
    d.fields.name_format_code = 4'h1;
    d.flags.world_wide = 1'h1;
    d.flags.lan_bit_error = 1'h1;
    d.fields.universal_lan_address = 48'h3D5A94000080;
    dec({64'h10003D5A94000080, 64'h0}, d);
    d.fields.universal_lan_address = 48'h3C5A94000080;
    dec({64'h10013C5A94000080, 64'h0}, d);
    d = '0;
    d.fields.name_format_code = 4'h5;
    d.flags.world_wide = 1'h1;
    d.fields.registered_org_id = 24'h3C5A94;
    d.fields.vendor_specific_id = 36'hB1734F62D;
    dec({64'h53C5A94B1734F62D, 64'h0}, d);
    d.fields.name_format_code = 4'h6;
    d.flags = '0;
    d.flags.long_name = 1'h1;
    d.fields.vendor_id_ext = 64'h1234567890ABCDEF;
    dec(128'h63C5A94B1734F62D1234567890ABCDEF, d);
    d = '0;
    d.fields.name_format_code = 4'h3;
    d.fields.local_value = 60'h123456789ABCDEF;
    dec({64'h3123456789ABCDEF, 64'h0}, d);
    d = '0;
    d.flags.absent = 1'h1;
    dec({64'h0123456789ABCDEF, 64'h0}, d);
    d = '0;
    d.fields.name_format_code = 4'hC;
    d.fields.registered_org_id = 24'h0CABCD;
    d.fields.eui_vendor_id = 40'hE123456789;
    dec({64'hC3ABCDE123456789, 64'h0}, d);
    d.fields.name_format_code = 4'hF;
    d.fields.registered_org_id = 24'hFCABCD;
    dec({64'hFFABCDE123456789, 64'h0}, d);
    for (int c = 4; c <= 11; c++)
    begin
      if (c == 5 || c == 6)
        continue;
      d = '0;
      d.fields.name_format_code = c[3:0];
      d.flags.unsupported = 1'h1;
      dec({c[3:0], 124'h3C5A94B1734F62D}, d);
    end
  endtask
  task automatic t_encode;
    nic_fields_type f;
    f = '0;
    f.name_format_code = 4'h1;
    f.universal_lan_address = 48'h3F5A94000080;
    e = '0;
    e.name = {64'h10003C5A94000080, 64'h0};
    e.flags.world_wide = 1'h1;
    e.flags.lan_bit_error = 1'h1;
    enc(f, e);
    f.name_format_code = 4'h2;
    f.universal_lan_address = 48'h3C5A94000080;
    f.vendor_ext12 = 12'hB17;
    f.vendor_id_ext = 64'h1234567890ABCDEF;
    e.name = {64'h2B173C5A94000080, 64'h0};
    e.flags.lan_bit_error = 1'h0;
    enc(f, e);
    f = '0;
    f.name_format_code = 4'h3;
    f.local_value = 60'h123456789ABCDEF;
    f.registered_org_id = 24'h3C5A94;
    e = '0;
    e.name = {64'h3123456789ABCDEF, 64'h0};
    enc(f, e);
    f.name_format_code = 4'h5;
    f.vendor_specific_id = 36'hB1734F62D;
    f.vendor_id_ext = 64'h1234567890ABCDEF;
    e.name = {64'h53C5A94B1734F62D, 64'h0};
    e.flags.world_wide = 1'h1;
    enc(f, e);
    f.name_format_code = 4'h6;
    e.name = 128'h63C5A94B1734F62D1234567890ABCDEF;
    e.flags.world_wide = 1'h0;
    e.flags.long_name = 1'h1;
    enc(f, e);
    f = '0;
    f.name_format_code = 4'hC;
    f.registered_org_id = 24'h0FABCD;
    f.eui_vendor_id = 40'hE123456789;
    e = '0;
    e.name = {64'hC3ABCDE123456789, 64'h0};
    enc(f, e);
    f = '1;
    f.name_format_code = 4'h0;
    e = '0;
    e.flags.absent = 1'h1;
    enc(f, e);
    f.name_format_code = 4'h7;
    e = '0;
    e.name = {4'h7, 124'h0};
    e.flags.unsupported = 1'h1;
    enc(f, e);
  endtask
  task automatic t_ce_low;
    @(posedge clock_i) ce_i <= 1'b0;
    dec({64'h3000000000000001, 64'h0}, d);
    @(posedge clock_i) ce_i <= 1'b1;
  endtask
  task complete_run;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    ce_i <= 1'b1;
    #1 cmp_dec('0, 1'b0);
    cmp_enc('0, 1'b0);
    t_decode();
    t_ce_low();
    t_encode();
    complete_run();
  end
endmodule
bind nic_codec nic_codec_asserts i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .dec_valid_i(dec_valid_i), .dec_name_i(dec_name_i), .enc_valid_i(enc_valid_i),
  .enc_fields_i(enc_fields_i), .dec_valid_o(dec_valid_o), .dec_out_o(dec_out_o),
  .enc_valid_o(enc_valid_o), .enc_out_o(enc_out_o));
